// *** design/imq_pkg.sv ***
// Purpose: Shared constants and types of the message-queue unit
// Assumes: APB register map, 20-bit list pointer offsets
// Notes: Pointer index N sits at PTR_OFS + 4*N
package imq_pkg;
  // Register byte offsets
  localparam logic [11:0] CS_OFS = 12'h000;
  localparam logic [11:0] PTR_OFS = 12'h004;
  localparam logic [11:0] PTR_LAST_OFS = 12'h020;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h024;
  localparam logic [11:0] IRQ_EN_OFS = 12'h028;
  localparam logic [11:0] IRQ_DIR_OFS = 12'h02c;
  localparam logic [11:0] OP_MASK_OFS = 12'h030;
  localparam logic [11:0] OP_STAT_OFS = 12'h034;
  // Field positions
  localparam int CS_EN_BIT = 0;
  localparam int CS_DEPTH_LSB = 1;
  localparam int CS_BASE_LSB = 20;
  localparam int IRQ_IPN_BIT = 0;
  localparam int IRQ_COND_LSB = 2;
  // Sizes
  localparam int PTR_W = 20;
  localparam int NPTR = 8;
  localparam int NLIST = 4;
  // Pointer indices
  localparam logic [2:0] PI_IF_BOT = 3'h0;
  localparam logic [2:0] PI_IF_TOP = 3'h1;
  localparam logic [2:0] PI_IP_TOP = 3'h2;
  localparam logic [2:0] PI_IP_BOT = 3'h3;
  localparam logic [2:0] PI_OF_BOT = 3'h4;
  localparam logic [2:0] PI_OF_TOP = 3'h5;
  localparam logic [2:0] PI_OP_TOP = 3'h6;
  localparam logic [2:0] PI_OP_BOT = 3'h7;
  // List indices: in_free, in_post, out_free, out_post
  localparam logic [1:0] LI_IF = 2'h0;
  localparam logic [1:0] LI_IP = 2'h1;
  localparam logic [1:0] LI_OF = 2'h2;
  localparam logic [1:0] LI_OP = 2'h3;
  localparam logic [2:0] LIST_TOP [NLIST] = '{PI_IF_TOP, PI_IP_TOP, PI_OF_TOP, PI_OP_TOP};
  localparam logic [2:0] LIST_BOT [NLIST] = '{PI_IF_BOT, PI_IP_BOT, PI_OF_BOT, PI_OP_BOT};
  // Queue access kinds {outbound, write}
  localparam logic [1:0] KIND_IN_RD = 2'h0;
  localparam logic [1:0] KIND_IN_WR = 2'h1;
  localparam logic [1:0] KIND_OUT_RD = 2'h2;
  localparam logic [1:0] KIND_OUT_WR = 2'h3;
  // Values
  localparam logic [19:0] PTR_RST = 20'h00000;
  localparam logic [19:0] PTR_STEP = 20'h00004;
  localparam logic [19:0] DEPTH_BYTES_MIN = 20'h00400;
  localparam logic [31:0] EMPTY_WORD = 32'hffff_ffff;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_LBUS = 2'b10
  } imq_state_t;

  // Advance by one word, wrapping inside the list's aligned block
  function automatic logic [19:0] ptr_step(input logic [19:0] p, input logic [19:0] m);
    ptr_step = (p & ~m) | ((p + PTR_STEP) & m);
  endfunction : ptr_step
endpackage : imq_pkg

// *** design/imq_lb_if.sv ***
// Purpose: Request and answer path to the local-bus engine
// Assumes: start and done are one-cycle pulses
// Notes: Engine accepts start only while idle
`timescale 1ns/1ps
`default_nettype none
interface imq_lb_if;
  logic start;
  logic write;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic done;
  logic [31:0] rdata;
  modport ctl (output start, write, addr, wdata, input done, rdata);
  modport eng (input start, write, addr, wdata, output done, rdata);
endinterface : imq_lb_if
`default_nettype wire

// *** design/imq_list_status.sv ***
// Purpose: Empty and full judgement for one circular list
// Assumes: Pointers share one aligned block of mask+1 bytes
// Notes: One slot stays unused so equal pointers always mean empty
`timescale 1ns/1ps
`default_nettype none
module imq_list_status (
  input wire logic [19:0] top, // Write-side pointer
  input wire logic [19:0] bottom, // Read-side pointer
  input wire logic [19:0] mask, // List size minus one
  output logic empty, // Nothing to pop
  output logic full // No room to push
);
  // Equal pointers read as empty, never as full
  assign empty = (top == bottom);
  assign full = (imq_pkg::ptr_step(top, mask) == bottom);
endmodule : imq_list_status
`default_nettype wire

// *** design/imq_lb_engine.sv ***
// Purpose: Local-bus master for delayed queue reads and writes
// Assumes: lb_ack is a one-cycle answer, lb_rdata valid with it
// Notes: One transfer at a time; start while busy is ignored
`timescale 1ns/1ps
`default_nettype none
module imq_lb_engine (
  input wire logic sys_clk, // Bridge clock
  input wire logic reset, // Async, active high
  imq_lb_if.eng lb, // Queue controller side
  output logic lb_req, // Transfer request, held to ack
  output logic lb_write, // Write when high
  output logic [31:0] lb_addr, // Local address
  output logic [31:0] lb_wdata, // Write data
  input wire logic lb_ack, // Transfer done
  input wire logic [31:0] lb_rdata // Read data at ack
);
  // Request side: hold until the slave answers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lb_req <= 1'b0;
      lb_write <= 1'b0;
      lb_addr <= 32'h0;
      lb_wdata <= 32'h0;
    end else if (lb.start && !lb_req) begin
      lb_req <= 1'b1;
      lb_write <= lb.write;
      lb_addr <= lb.addr;
      lb_wdata <= lb.wdata;
    end else if (lb_req && lb_ack) begin
      lb_req <= 1'b0;
    end
  end

  // Answer side: one-cycle done with captured data
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lb.done <= 1'b0;
      lb.rdata <= 32'h0;
    end else begin
      lb.done <= lb_req && lb_ack;
      if (lb_req && lb_ack) begin
        lb.rdata <= lb_rdata;
      end
    end
  end
endmodule : imq_lb_engine
`default_nettype wire

// *** design/imq_top.sv ***
// Purpose: Message-queue unit: queue ports, list pointers, interrupts
// Assumes: Queue requester holds pq_req and its fields until pq_ack
// Notes: APB answers with no wait state; unmapped gives pslverr
`timescale 1ns/1ps
`default_nettype none
module imq_top (
  input wire logic sys_clk, // Bridge clock, 100 MHz
  input wire logic reset, // Async, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  input wire logic pq_req, // Queue port access, held to ack
  input wire logic pq_outbound, // 1 outbound port, 0 inbound
  input wire logic pq_write, // 1 write, 0 read
  input wire logic [31:0] pq_wdata, // Frame offset written
  output logic pq_ack, // One-cycle answer
  output logic [31:0] pq_rdata, // Frame offset read
  output logic lb_req, // Local request
  output logic lb_write, // Local write
  output logic [31:0] lb_addr, // Local address
  output logic [31:0] lb_wdata, // Local write data
  input wire logic lb_ack, // Local answer
  input wire logic [31:0] lb_rdata, // Local read data
  output logic pci_irq, // PCI interrupt, high active
  output logic local_irq // Local interrupt, high active
);
  imq_lb_if lbi ();

  imq_pkg::imq_state_t state_q;
  logic [19:0] ptr_q [imq_pkg::NPTR];
  logic [11:0] base_q;
  logic [2:0] depth_q;
  logic en_q;
  logic in_post_new_irq_enable_q;
  logic ipn_flag_q;
  logic op_flag_q;
  logic op_mask_q;
  logic [3:0] cond_en_q;
  logic [3:0] dir_q;
  logic [1:0] kind_q;
  logic [2:0] pidx_q;
  logic [1:0] list_q;
  logic [3:0] empty;
  logic [3:0] full;
  logic [3:0] cond;
  logic [19:0] depth_mask;
  logic [1:0] req_kind;
  logic [2:0] sel_ptr;
  logic [1:0] sel_list;
  logic blocked;
  logic take;
  logic done_ok;
  logic adv;
  logic ipn_set;
  logic apb_setup;
  logic apb_wr;
  logic ptr_hit;
  logic [2:0] apb_idx;
  logic [31:0] rd_data;

  // Address decode shared by read-data and error paths
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= imq_pkg::OP_STAT_OFS);
  endfunction : mapped

  // List size as a byte mask
  assign depth_mask = (imq_pkg::DEPTH_BYTES_MIN << depth_q) - 20'h1;

  // Per-list empty and full
  for (genvar g = 0; g < imq_pkg::NLIST; g++) begin : g_list
    imq_list_status u_stat (
      .top(ptr_q[imq_pkg::LIST_TOP[g]]),
      .bottom(ptr_q[imq_pkg::LIST_BOT[g]]),
      .mask(depth_mask),
      .empty(empty[g]),
      .full(full[g])
    );
  end

  // Interrupt conditions: in-free empty, out-free empty, in-post full, out-free full
  assign cond = {full[imq_pkg::LI_OF], full[imq_pkg::LI_IP],
                 empty[imq_pkg::LI_OF], empty[imq_pkg::LI_IF]};

  // Local-bus engine
  imq_lb_engine u_eng (
    .sys_clk(sys_clk),
    .reset(reset),
    .lb(lbi.eng),
    .lb_req(lb_req),
    .lb_write(lb_write),
    .lb_addr(lb_addr),
    .lb_wdata(lb_wdata),
    .lb_ack(lb_ack),
    .lb_rdata(lb_rdata)
  );

  // Which pointer and list a queue access uses
  assign req_kind = {pq_outbound, pq_write};
  always_comb begin
    case (req_kind)
      imq_pkg::KIND_IN_RD: begin
        sel_ptr = imq_pkg::PI_IF_BOT;
        sel_list = imq_pkg::LI_IF;
      end
      imq_pkg::KIND_IN_WR: begin
        sel_ptr = imq_pkg::PI_IP_TOP;
        sel_list = imq_pkg::LI_IP;
      end
      imq_pkg::KIND_OUT_RD: begin
        sel_ptr = imq_pkg::PI_OP_BOT;
        sel_list = imq_pkg::LI_OP;
      end
      default: begin
        sel_ptr = imq_pkg::PI_OF_TOP;
        sel_list = imq_pkg::LI_OF;
      end
    endcase
  end

  // Reads stop on empty, writes on full; a disabled unit refuses all
  assign blocked = !en_q || (pq_write ? full[sel_list] : empty[sel_list]);
  assign take = pq_req && (state_q == imq_pkg::ST_IDLE) && !pq_ack;
  // Checked again at completion, since software may move pointers meanwhile
  assign done_ok = kind_q[0] ? !full[list_q] : !empty[list_q];
  assign adv = (state_q == imq_pkg::ST_LBUS) && lbi.done && done_ok;
  assign ipn_set = adv && (kind_q == imq_pkg::KIND_IN_WR);

  // Queue sequencer: refused accesses answer at once, others after the local transfer
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= imq_pkg::ST_IDLE;
      kind_q <= 2'h0;
      pidx_q <= 3'h0;
      list_q <= 2'h0;
      pq_ack <= 1'b0;
      pq_rdata <= 32'h0;
      lbi.start <= 1'b0;
      lbi.write <= 1'b0;
      lbi.addr <= 32'h0;
      lbi.wdata <= 32'h0;
    end else begin
      pq_ack <= 1'b0;
      lbi.start <= 1'b0;
      case (state_q)
        imq_pkg::ST_IDLE: begin
          if (take && blocked) begin
            pq_ack <= 1'b1;
            pq_rdata <= imq_pkg::EMPTY_WORD;
          end else if (take) begin
            kind_q <= req_kind;
            pidx_q <= sel_ptr;
            list_q <= sel_list;
            lbi.start <= 1'b1;
            lbi.write <= pq_write;
            lbi.addr <= {base_q, ptr_q[sel_ptr]};
            lbi.wdata <= pq_wdata;
            state_q <= imq_pkg::ST_LBUS;
          end
        end
        imq_pkg::ST_LBUS: begin
          if (lbi.done) begin
            pq_ack <= 1'b1;
            pq_rdata <= kind_q[0] ? 32'h0 : lbi.rdata;
            state_q <= imq_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= imq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // APB phases; access completes one cycle after setup
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready && pwrite;
  assign ptr_hit = (paddr >= imq_pkg::PTR_OFS) && (paddr <= imq_pkg::PTR_LAST_OFS);
  assign apb_idx = 3'((paddr - imq_pkg::PTR_OFS) >> 2);

  // Eight pointers; a hardware advance beats a same-cycle software write
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < imq_pkg::NPTR; i++) begin
        ptr_q[i] <= imq_pkg::PTR_RST;
      end
    end else begin
      if (apb_wr && ptr_hit && (paddr[1:0] == 2'h0)) begin
        ptr_q[apb_idx] <= pwdata[19:0];
      end
      if (adv) begin
        ptr_q[pidx_q] <= imq_pkg::ptr_step(ptr_q[pidx_q], depth_mask);
      end
    end
  end

  // Control and enable registers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      base_q <= 12'h0;
      depth_q <= 3'h0;
      en_q <= 1'b0;
      in_post_new_irq_enable_q <= 1'b0;
      cond_en_q <= 4'h0;
      dir_q <= 4'h0;
      op_mask_q <= 1'b0;
    end else if (apb_wr) begin
      case (paddr)
        imq_pkg::CS_OFS: begin
          base_q <= pwdata[imq_pkg::CS_BASE_LSB +: 12];
          depth_q <= pwdata[imq_pkg::CS_DEPTH_LSB +: 3];
          en_q <= pwdata[imq_pkg::CS_EN_BIT];
        end
        imq_pkg::IRQ_EN_OFS: begin
          in_post_new_irq_enable_q <= pwdata[imq_pkg::IRQ_IPN_BIT];
          cond_en_q <= pwdata[imq_pkg::IRQ_COND_LSB +: 4];
        end
        imq_pkg::IRQ_DIR_OFS: begin
          dir_q <= pwdata[imq_pkg::IRQ_COND_LSB +: 4];
        end
        imq_pkg::OP_MASK_OFS: begin
          op_mask_q <= pwdata[0];
        end
        default: begin
        end
      endcase
    end
  end

  // New-entry flag: a set in the clearing cycle survives
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ipn_flag_q <= 1'b0;
    end else if (ipn_set) begin
      ipn_flag_q <= 1'b1;
    end else if (apb_wr && (paddr == imq_pkg::IRQ_STAT_OFS) && pwdata[imq_pkg::IRQ_IPN_BIT]) begin
      ipn_flag_q <= 1'b0;
    end
  end

  // Out-post flag follows list occupancy, so it drops after the last pop
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      op_flag_q <= 1'b0;
    end else begin
      op_flag_q <= !empty[imq_pkg::LI_OP];
    end
  end

  // Interrupt lines; direction bit 1 steers a condition to PCI
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pci_irq <= 1'b0;
      local_irq <= 1'b0;
    end else begin
      pci_irq <= (op_flag_q && !op_mask_q) || |(cond & cond_en_q & dir_q);
      local_irq <= (ipn_flag_q && in_post_new_irq_enable_q) || |(cond & cond_en_q & ~dir_q);
    end
  end

  // Read mux; reserved bits read zero
  always_comb begin
    rd_data = 32'h0;
    if (ptr_hit) begin
      rd_data = {base_q, ptr_q[apb_idx]};
    end else begin
      case (paddr)
        imq_pkg::CS_OFS: rd_data = {base_q, 4'h0, full, empty, 4'h0, depth_q, en_q};
        imq_pkg::IRQ_STAT_OFS: rd_data = {26'h0, cond, op_flag_q, ipn_flag_q};
        imq_pkg::IRQ_EN_OFS: rd_data = {26'h0, cond_en_q, 1'b0, in_post_new_irq_enable_q};
        imq_pkg::IRQ_DIR_OFS: rd_data = {26'h0, dir_q, 2'h0};
        imq_pkg::OP_MASK_OFS: rd_data = {31'h0, op_mask_q};
        imq_pkg::OP_STAT_OFS: rd_data = {31'h0, op_flag_q};
        default: rd_data = 32'h0;
      endcase
    end
  end

  // APB answer: data and error sampled at setup, held through access
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !mapped(paddr);
      if (apb_setup) begin
        prdata <= (pwrite || !mapped(paddr)) ? 32'h0 : rd_data;
      end
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_empty_out_read;
    take && (req_kind == imq_pkg::KIND_OUT_RD) && blocked && !apb_wr;
  endsequence

  a_post_flag_set: assert property (ipn_set |=> ipn_flag_q)
    else $error("new-entry flag not set after post");
  a_free_empty_ones: assert property (
    take && (req_kind == imq_pkg::KIND_IN_RD) && blocked
    |=> pq_ack && (pq_rdata == imq_pkg::EMPTY_WORD))
    else $error("empty inbound read not all ones");
  a_pci_irq_raise: assert property ((!empty[3] && !op_mask_q && !dir_q[0])[*2] |=> pci_irq)
    else $error("pci interrupt missing while out-post list holds entries");
  a_op_flag_clear: assert property (empty[3][*2] |-> !op_flag_q)
    else $error("out-post flag stuck after list emptied");
  a_post_addr: assert property (lbi.start && (kind_q == imq_pkg::KIND_IN_WR)
    |-> lbi.addr == {base_q, ptr_q[imq_pkg::PI_IP_TOP]})
    else $error("inbound post written at wrong address");
  a_out_no_pop: assert property (
    s_empty_out_read |=> $stable(ptr_q[imq_pkg::PI_OP_BOT])
    ##1 (state_q == imq_pkg::ST_IDLE))
    else $error("empty outbound read moved pointer");
  a_flag_w1c: assert property (
    apb_wr && (paddr == imq_pkg::IRQ_STAT_OFS) && pwdata[0]
    && !ipn_set |=> !ipn_flag_q)
    else $error("new-entry flag not cleared by write of one");
  a_done_ack: assert property ((state_q == imq_pkg::ST_LBUS) && lbi.done
    |=> pq_ack ##1 !pq_ack)
    else $error("queue answer not a single pulse after transfer");
endmodule : imq_top
`default_nettype wire

// *** tb/imq_lb_model.sv ***
// Purpose: Local memory that answers the unit's local-bus transfers
// Assumes: One transfer at a time, request held until the answer
// Notes: Random latency of 0 to 3 extra cycles per transfer
`timescale 1ns/1ps
`default_nettype none
module imq_lb_model (
  input wire logic sys_clk, // Bridge clock
  input wire logic lb_req, // Request from the unit
  input wire logic lb_write, // Write when high
  input wire logic [31:0] lb_addr, // Byte address
  input wire logic [31:0] lb_wdata, // Write data
  output logic lb_ack, // One-cycle answer
  output logic [31:0] lb_rdata // Read data with the answer
);
  logic [31:0] mem [1024];
  integer seed_q = 31792;
  integer wait_q = 0;
  initial begin
    lb_ack = 1'b0;
    lb_rdata = 32'h0000_0000;
  end
  // Data line toggles outside answers so stale data cannot pass as valid
  always @(posedge sys_clk) begin
    lb_ack <= 1'b0;
    lb_rdata <= ~lb_rdata;
    if (lb_req && !lb_ack) begin
      if (wait_q == 0) begin
        lb_ack <= 1'b1;
        if (lb_write) mem[lb_addr[11:2]] <= lb_wdata;
        else lb_rdata <= mem[lb_addr[11:2]];
        wait_q <= $unsigned($random(seed_q)) % 4;
      end else begin
        wait_q <= wait_q - 1;
      end
    end
  end
endmodule : imq_lb_model
`default_nettype wire

// *** tb/test_imq_top.sv ***
// Purpose: Self-checking bench of the message-queue unit
// Assumes: List size 0x400, lists at 0x000, 0x400, 0x800 and 0xc00
// Notes: Software pointer steps are done over APB by the bench
`timescale 1ns/1ps
`default_nettype none
module test_imq_top;
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, err_v;
  logic pq_req, pq_outbound, pq_write, pq_ack, lb_req, lb_write, lb_ack, pci_irq, local_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pq_wdata, pq_rdata, lb_addr, lb_wdata, lb_rdata, rv;
  logic [31:0] w [5];
  logic [19:0] pv [8] = '{20'h0, 20'hc, 20'h400, 20'h400, 20'h800, 20'h800, 20'hc00, 20'hc00};
  integer seed = 31792;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;

  imq_top u_imq_top (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pq_req, .pq_outbound, .pq_write, .pq_wdata, .pq_ack, .pq_rdata,
    .lb_req, .lb_write, .lb_addr, .lb_wdata, .lb_ack, .lb_rdata, .pci_irq, .local_irq);
  imq_lb_model u_imq_lb_model (.sys_clk, .lb_req, .lb_write, .lb_addr, .lb_wdata, .lb_ack,
    .lb_rdata);

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop();
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // Run needs under 2000 cycles; a hang ends here
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // APB transfer held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rv = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rv, exp);
  endtask : rdc

  function automatic logic [11:0] ptr_a(input int i);
    ptr_a = imq_pkg::PTR_OFS + 12'(4 * i);
  endfunction : ptr_a

  // Expected pointer after one step; the last slot of a 0x400-byte list wraps to its start
  function automatic logic [19:0] nxt(input logic [19:0] p);
    nxt = ((p & 20'h003ff) == 20'h003fc) ? (p - 20'h003fc) : (p + 20'h00004);
  endfunction : nxt

  // Expected control word: base 0xa00, depth 0, enabled
  function automatic logic [31:0] cs_exp(input logic [3:0] f, input logic [3:0] e);
    cs_exp = {12'ha00, 4'h0, f, e, 8'h01};
  endfunction : cs_exp

  // Pointer reads show the window base above the offset
  task automatic pr(input int i, input logic [19:0] p);
    rdc(ptr_a(i), {12'ha00, p});
  endtask : pr

  task automatic pw(input int i, input logic [19:0] p);
    apb(1'b1, ptr_a(i), {12'h0, p});
  endtask : pw

  // Queue access held until the one-cycle answer
  task automatic q(input logic ob, input logic wq, input logic [31:0] d);
    @(posedge sys_clk);
    pq_req <= 1'b1;
    pq_outbound <= ob;
    pq_write <= wq;
    pq_wdata <= d;
    do @(posedge sys_clk); while (pq_ack !== 1'b1);
    rv = pq_rdata;
    pq_req <= 1'b0;
  endtask : q

  // Main sequence
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pq_req = 1'b0;
    pq_outbound = 1'b0;
    pq_write = 1'b0;
    pq_wdata = 32'h0;
    for (int i = 0; i < 5; i++) w[i] = $random(seed);
    for (int i = 0; i < 3; i++) u_imq_lb_model.mem[i] = w[i];
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rdc(imq_pkg::CS_OFS, 32'h0000_0f00);
    apb(1'b0, 12'h038, 32'h0);
    check({31'h0, err_v}, 32'h1);
    for (int i = 0; i < 8; i++) pw(i, pv[i]);
    apb(1'b1, imq_pkg::CS_OFS, 32'ha000_0001);
    for (int i = 0; i < 4; i++) begin
      q(1'b0, 1'b0, 32'h0);
      check(rv, (i < 3) ? w[i] : imq_pkg::EMPTY_WORD);
    end
    pr(0, 20'hc);
    apb(1'b1, imq_pkg::IRQ_EN_OFS, 32'h1);
    q(1'b0, 1'b1, w[3]);
    check(u_imq_lb_model.mem[256], w[3]);
    pr(2, nxt(20'h400));
    check({31'h0, local_irq}, 32'h1);
    apb(1'b1, imq_pkg::IRQ_STAT_OFS, 32'h0);
    rdc(imq_pkg::IRQ_STAT_OFS, 32'hd);
    apb(1'b1, imq_pkg::IRQ_STAT_OFS, 32'h1);
    rdc(imq_pkg::IRQ_STAT_OFS, 32'hc);
    check({31'h0, local_irq}, 32'h0);
    rdc(imq_pkg::CS_OFS, cs_exp(4'h0, 4'hd));
    u_imq_lb_model.mem[768] = w[4];
    pw(6, 20'hc04);
    repeat (3) @(posedge sys_clk);
    check({31'h0, pci_irq}, 32'h1);
    rdc(imq_pkg::OP_STAT_OFS, 32'h1);
    rdc(imq_pkg::IRQ_STAT_OFS, 32'he);
    apb(1'b1, imq_pkg::OP_MASK_OFS, 32'h1);
    repeat (3) @(posedge sys_clk);
    check({31'h0, pci_irq}, 32'h0);
    apb(1'b1, imq_pkg::OP_MASK_OFS, 32'h0);
    q(1'b1, 1'b0, 32'h0);
    check(rv, w[4]);
    pr(7, nxt(20'hc00));
    rdc(imq_pkg::OP_STAT_OFS, 32'h0);
    check({31'h0, pci_irq}, 32'h0);
    q(1'b1, 1'b0, 32'h0);
    check(rv, imq_pkg::EMPTY_WORD);
    pr(7, 20'hc04);
    q(1'b1, 1'b1, w[0]);
    check(u_imq_lb_model.mem[512], w[0]);
    pr(5, nxt(20'h800));
    pw(2, 20'h7fc);
    pw(3, 20'h404);
    q(1'b0, 1'b1, w[1]);
    check(u_imq_lb_model.mem[511], w[1]);
    pr(2, nxt(20'h7fc));
    rdc(imq_pkg::CS_OFS, cs_exp(4'h2, 4'h9));
    pr(4, 20'h800);
    pw(4, nxt(20'h800));
    rdc(imq_pkg::CS_OFS, cs_exp(4'h2, 4'hd));
    q(1'b0, 1'b1, w[2]);
    pr(2, 20'h400);
    check(u_imq_lb_model.mem[256], w[3]);
    apb(1'b1, imq_pkg::IRQ_EN_OFS, 32'h10);
    apb(1'b1, imq_pkg::IRQ_DIR_OFS, 32'h10);
    repeat (3) @(posedge sys_clk);
    check({30'h0, pci_irq, local_irq}, 32'h2);
    apb(1'b1, imq_pkg::IRQ_DIR_OFS, 32'h0);
    repeat (3) @(posedge sys_clk);
    check({30'h0, pci_irq, local_irq}, 32'h1);
    report_and_stop();
  end
endmodule : test_imq_top
`default_nettype wire
